/* File: verilog/event_counter_channel.v */
/*
 one external event counter channel with an apb register slave.
 assumes an apb master on core_clk and an asynchronous event pin.
*/
// Contract
// - The counter decrements once per valid edge on the event pin.
// - Writing one to the start trigger starts counting while the clock gate bit is set, the only start.
// - Writing one to the stop trigger halts counting.
// - An interrupt follows after compare plus one valid edges.
// - The count is always readable and cannot be written.
// - A running flag shows enabled or stopped, set by the triggers.
// - An overflow flag is readable in the channel status word.
// - On channels 1 and 3 a bit selects one 16-bit or split 8-bit use.
// - A two-bit field selects the valid edge of the event pin.
// - A function field selects the mode; a bit asks a start interrupt.
// - From zero the next event reloads from compare and interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.vh"

module event_counter_channel #(
	parameter CHANNEL = 1,
	parameter WIDTH   = 16
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_b,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// event pin
	input  wire        chan_event_input,
	// interrupt
	output reg         irq
);
	// split only exists on channels 1 and 3
	localparam HAS_SPLIT = (CHANNEL == 1) || (CHANNEL == 3);

	reg              unit0_clock_enable;
	reg              chan_running_flag;
	reg  [11:0]      modeReg;
	reg  [WIDTH-1:0] chan_compare_value;
	reg              overflow_flag;
	reg  [1:0]       irqStatus;
	reg  [1:0]       irqMask;
	reg              startPulse;

	wire [WIDTH-1:0] chan_count_value;
	wire             wrapped;
	wire             edgeSeen;

	wire access = psel & penable;
	wire wrAcc  = access & pwrite;

	wire [2:0] function_select_hi = modeReg[`MODE_FUNC_HI:`MODE_FUNC_LO];
	wire       start_irq_select   = modeReg[`MODE_START_IRQ];
	wire [1:0] edgeSel = {modeReg[`MODE_EDGE_HI], modeReg[`MODE_EDGE_LO]};
	wire half_width_select = HAS_SPLIT ? modeReg[`MODE_SPLIT] : 1'b0;

	wire isEventMode = (function_select_hi == `FUNC_EVENT_COUNT);

	wire startHit = wrAcc && (paddr == `OFS_START_TRIGGER) && pwdata[0]
		&& unit0_clock_enable;
	wire stopHit = wrAcc && (paddr == `OFS_STOP_TRIGGER) && pwdata[0];

	wire countStep = chan_running_flag & isEventMode & edgeSeen
		& unit0_clock_enable;

	function known;
		input [11:0] a;
		begin
			known = (a == `OFS_CLOCK_GATE) || (a == `OFS_START_TRIGGER)
				|| (a == `OFS_STOP_TRIGGER) || (a == `OFS_RUNNING)
				|| (a == `OFS_MODE) || (a == `OFS_COMPARE)
				|| (a == `OFS_COUNT) || (a == `OFS_STATUS_WORD)
				|| (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK);
		end
	endfunction

	edge_detector u_edge (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pinIn    (chan_event_input),
		.edgeSel  (edgeSel),
		.edgeSeen (edgeSeen)
	);

	down_counter #(
		.WIDTH (WIDTH)
	) u_count (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.load      (startPulse),
		.step      (countStep),
		.split     (half_width_select),
		.reloadVal (chan_compare_value),
		.count     (chan_count_value),
		.wrapped   (wrapped)
	);

	// register writes and trigger handling
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unit0_clock_enable <= 1'b0;
			chan_running_flag  <= 1'b0;
			modeReg            <= `RST_MODE;
			chan_compare_value <= `RST_COMPARE;
			irqMask            <= 2'h0;
			startPulse         <= 1'b0;
		end else begin
			startPulse <= startHit;
			if (startHit) begin
				chan_running_flag <= 1'b1;
			end else if (stopHit || !unit0_clock_enable) begin
				chan_running_flag <= 1'b0;
			end
			if (wrAcc) begin
				if (paddr == `OFS_CLOCK_GATE) begin
					unit0_clock_enable <= pwdata[0];
				end else if (paddr == `OFS_MODE && unit0_clock_enable) begin
					modeReg <= pwdata[11:0];
				end else if (paddr == `OFS_COMPARE && unit0_clock_enable) begin
					chan_compare_value <= pwdata[WIDTH-1:0];
				end else if (paddr == `OFS_IRQ_MASK) begin
					irqMask <= pwdata[1:0];
				end
			end
		end
	end

	// sticky flags: hardware set wins over software clear
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			overflow_flag <= 1'b0;
			irqStatus     <= 2'h0;
			irq           <= 1'b0;
		end else begin
			if (wrapped) begin
				overflow_flag <= 1'b1;
			end else if (wrAcc && paddr == `OFS_STATUS_WORD
				&& pwdata[`STAT_OVERFLOW]) begin
				overflow_flag <= 1'b0;
			end
			irqStatus[`IRQ_BIT_COUNT] <= wrapped
				| (irqStatus[`IRQ_BIT_COUNT]
				& ~(wrAcc && paddr == `OFS_IRQ_STATUS
				&& pwdata[`IRQ_BIT_COUNT]));
			irqStatus[`IRQ_BIT_START] <= (startPulse & start_irq_select)
				| (irqStatus[`IRQ_BIT_START]
				& ~(wrAcc && paddr == `OFS_IRQ_STATUS
				&& pwdata[`IRQ_BIT_START]));
			irq <= |(irqStatus & irqMask);
		end
	end

	// apb answer: ready in the access cycle, error on unmapped address
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~known(paddr);
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (paddr == `OFS_CLOCK_GATE) begin
					prdata[0] <= unit0_clock_enable;
				end else if (paddr == `OFS_RUNNING) begin
					prdata[0] <= chan_running_flag;
				end else if (paddr == `OFS_MODE) begin
					prdata[11:0] <= modeReg;
				end else if (paddr == `OFS_COMPARE) begin
					prdata[WIDTH-1:0] <= chan_compare_value;
				end else if (paddr == `OFS_COUNT) begin
					prdata[WIDTH-1:0] <= chan_count_value;
				end else if (paddr == `OFS_STATUS_WORD) begin
					prdata[`STAT_OVERFLOW] <= overflow_flag;
				end else if (paddr == `OFS_IRQ_STATUS) begin
					prdata[1:0] <= irqStatus;
				end else if (paddr == `OFS_IRQ_MASK) begin
					prdata[1:0] <= irqMask;
				end
			end
		end
	end
endmodule // event_counter_channel

`default_nettype wire

/* File: verilog/event_counter_regs.vh */
/*
 event counter channel: register offsets, field positions, reset values.
 assumes byte addressing on a 32-bit apb bus, one word per register.
*/
`ifndef EVENT_COUNTER_REGS_VH
`define EVENT_COUNTER_REGS_VH

// register byte offsets
`define OFS_CLOCK_GATE      12'h000
`define OFS_START_TRIGGER   12'h004
`define OFS_STOP_TRIGGER    12'h008
`define OFS_RUNNING         12'h00C
`define OFS_MODE            12'h010
`define OFS_COMPARE         12'h014
`define OFS_COUNT           12'h018
`define OFS_STATUS_WORD     12'h01C
`define OFS_IRQ_STATUS      12'h020
`define OFS_IRQ_MASK        12'h024

// mode register fields
`define MODE_START_IRQ      0
`define MODE_FUNC_LO        1
`define MODE_FUNC_HI        3
`define MODE_EDGE_LO        6
`define MODE_EDGE_HI        7
`define MODE_SPLIT          11

// function code for event counting
`define FUNC_EVENT_COUNT    3'h3

// edge select codes
`define EDGE_FALL           2'h0
`define EDGE_RISE           2'h1
`define EDGE_BOTH           2'h2

// status word / interrupt status bits
`define STAT_OVERFLOW       0
`define IRQ_BIT_COUNT       0
`define IRQ_BIT_START       1

// reset values
`define RST_MODE            12'h000
`define RST_COMPARE         16'h0000

`endif

/* File: verilog/edge_detector.v */
/*
 synchronises the event input pin and flags the chosen edge for one cycle.
 assumes an asynchronous pin; two flip-flops precede any logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.vh"

module edge_detector (
	// clock and reset
	input  wire       core_clk,
	input  wire       rst_b,
	// pin and selection
	input  wire       pinIn,
	input  wire [1:0] edgeSel,
	// result
	output reg        edgeSeen
);
	reg syncA;
	reg syncB;
	reg last;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA    <= 1'b0;
			syncB    <= 1'b0;
			last     <= 1'b0;
			edgeSeen <= 1'b0;
		end else begin
			syncA <= pinIn;
			syncB <= syncA;
			last  <= syncB;
			case (edgeSel)
			`EDGE_FALL: edgeSeen <= last & ~syncB;
			`EDGE_RISE: edgeSeen <= ~last & syncB;
			`EDGE_BOTH: edgeSeen <= last ^ syncB;
			default:    edgeSeen <= 1'b0;
			endcase
		end
	end
endmodule // edge_detector

`default_nettype wire

/* File: verilog/down_counter.v */
/*
 down counter with reload; 16-bit, or the low 8-bit half alone when split.
 assumes the caller gives one-cycle load and count strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.vh"

module down_counter #(
	parameter WIDTH = 16
) (
	// clock and reset
	input  wire             core_clk,
	input  wire             rst_b,
	// control
	input  wire             load,
	input  wire             step,
	input  wire             split,
	input  wire [WIDTH-1:0] reloadVal,
	// state
	output reg  [WIDTH-1:0] count,
	output reg              wrapped
);
	localparam H = WIDTH / 2;

	wire loZero = (count[H-1:0] == {H{1'b0}});
	wire allZero = (count == {WIDTH{1'b0}});

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count   <= {WIDTH{1'b0}};
			wrapped <= 1'b0;
		end else begin
			wrapped <= 1'b0;
			if (load) begin
				count <= reloadVal;
			end else if (step) begin
				if (split) begin
					// low half counts the events alone
					if (loZero) begin
						count[H-1:0] <= reloadVal[H-1:0];
						wrapped      <= 1'b1;
					end else begin
						count[H-1:0] <= count[H-1:0] - 1'b1;
					end
				end else if (allZero) begin
					count   <= reloadVal;
					wrapped <= 1'b1;
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule // down_counter

`default_nettype wire

/* File: verif/event_counter_channel_assertions.sv */
/*
 port checker for the event counter channel, bound to its top module.
 assumes zero wait state apb answers and a registered interrupt level.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.vh"

module event_counter_checker (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst_b,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pin and interrupt
	input wire logic        chan_event_input,
	input wire logic        irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence setup;
		psel && !penable;
	endsequence
	sequence rd_of(logic [11:0] a);
		pready && !pwrite && paddr == a;
	endsequence

	chk_ready_setup: assert property (setup |=> pready)
		else $error("no ready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held");
	chk_rdata_idle: assert property (!pready |-> prdata == 0)
		else $error("read data outside access");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_err_decode: assert property (pready |->
		pslverr == (paddr[1:0] != 2'h0 || paddr > 12'h024))
		else $error("wrong address decode");
	chk_run_narrow: assert property (rd_of(`OFS_RUNNING) |->
		prdata[31:1] == 0)
		else $error("running flag too wide");
	chk_count_narrow: assert property (rd_of(`OFS_COUNT) |->
		prdata[31:16] == 0)
		else $error("count too wide");
	chk_ovf_narrow: assert property (rd_of(`OFS_STATUS_WORD) |->
		prdata[31:1] == 0)
		else $error("status word too wide");
	chk_irq_masked: assert property (pready && pwrite &&
		paddr == `OFS_IRQ_MASK && pwdata[1:0] == 0 |-> ##2 !irq)
		else $error("irq high while masked");
endmodule // event_counter_checker

bind event_counter_channel event_counter_checker chk (.core_clk, .rst_b,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.chan_event_input, .irq);
`default_nettype wire

/* File: verif/event_source.sv */
/*
 external event source: sends a burst of pulses on the event pin.
 assumes the bench raises go for one cycle and waits on busy.
*/
`timescale 1ns/1ps
`default_nettype none

module event_source (
	// clock
	input wire logic       core_clk,
	// command
	input wire logic       go,
	input wire logic [7:0] pulses,
	input wire logic [7:0] gap,
	// pin side
	output var logic       pin,
	output var logic       busy
);
	initial begin
		pin = 0;
		busy = 0;
		forever begin
			@(posedge core_clk);
			if (go) begin
				busy <= 1;
				// gap sets the low and the high time of each pulse, in cycles
				repeat (pulses) begin
					repeat (gap) @(posedge core_clk);
					pin <= 1;
					repeat (gap) @(posedge core_clk);
					pin <= 0;
				end
				busy <= 0;
			end
		end
	end
endmodule // event_source
`default_nettype wire

/* File: verif/external_event_counter_channel_bench.sv */
/*
 bench for the event counter channel: apb master, count model, checks.
 assumes the design, its header, the checker and the event source.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.vh"

module external_event_counter_channel_bench;
	logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic        irq, go, pin, busy, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  pulses, gap;
	int          errors, check_count, cnt, cmp, wr, e, n, i;
	int          mult[4] = '{1, 1, 2, 0};

	event_counter_channel DUT (.core_clk, .rst_b, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.chan_event_input(pin), .irq);
	event_source src (.core_clk, .go, .pulses, .gap, .pin, .busy);

	task automatic finish_test;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bail(input int t, lim);
		if (t >= lim) begin
			errors++;
			finish_test;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk) penable <= 1;
		do begin
			@(posedge core_clk);
			t++;
		end while (pready !== 1 && t < 50);
		bail(t, 50);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask
	task automatic send(input int p);
		int t;
		t = 0;
		pulses <= 8'(p);
		gap <= 8'(3 + $urandom % 6);
		go <= 1;
		@(posedge core_clk) go <= 0;
		do begin
			@(posedge core_clk);
			t++;
		end while ((busy !== 0 || t < 2) && t < 3000);
		bail(t, 3000);
		// let the pin synchroniser and edge flop settle
		repeat (8) @(posedge core_clk);
	endtask
	task automatic edges(input int k);
		repeat (k) begin
			if (cnt == 0) begin
				cnt = cmp;
				wr = 1;
			end else
				cnt--;
		end
	endtask

	initial begin
		core_clk = 0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		rst_b = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		go = 0;
		pulses = 0;
		gap = 3;
		errors = 0;
		check_count = 0;
		n = $urandom(32'h6c84);
		repeat (6) @(posedge core_clk);
		rst_b <= 1;
		@(posedge core_clk);
		for (i = 0; i < 10; i++)
			if (i != 1 && i != 2) begin
				apb(0, 12'(4 * i), 0);
				check("reset", rd, 0);
			end
		apb(0, 12'h028, 0);
		check("slverr", se, 1);
		apb(1, `OFS_MODE, 32'h0000_0046);
		apb(1, `OFS_START_TRIGGER, 1);
		apb(0, `OFS_MODE, 0);
		check("gated", rd, 0);
		apb(0, `OFS_RUNNING, 0);
		check("run", rd, 0);
		apb(1, `OFS_CLOCK_GATE, 1);
		apb(1, `OFS_IRQ_MASK, 3);
		for (e = 0; e < 4; e++) begin
			cmp = 2 + $urandom % 4;
			n = (e == 1) ? cmp + 1 : 1 + $urandom % 3;
			apb(1, `OFS_COMPARE, cmp);
			apb(1, `OFS_MODE, 32'h0000_0007 | e << 6);
			apb(1, `OFS_START_TRIGGER, 1);
			cnt = cmp;
			wr = 0;
			repeat (3) @(posedge core_clk);
			apb(0, `OFS_RUNNING, 0);
			check("run", rd, 1);
			apb(0, `OFS_IRQ_STATUS, 0);
			check("sirq", rd, 2);
			check("irq", irq, 1);
			apb(1, `OFS_IRQ_STATUS, 2);
			send(n);
			edges(n * mult[e]);
			apb(1, `OFS_COUNT, $urandom);
			apb(0, `OFS_COUNT, 0);
			check("count", rd, cnt);
			apb(0, `OFS_STATUS_WORD, 0);
			check("ovf", rd, wr);
			apb(0, `OFS_IRQ_STATUS, 0);
			check("wrap", rd, wr);
			apb(1, `OFS_STATUS_WORD, 1);
			apb(1, `OFS_IRQ_STATUS, 1);
			apb(1, `OFS_STOP_TRIGGER, 1);
			send(1);
			apb(0, `OFS_COUNT, 0);
			check("stop", rd, cnt);
			apb(0, `OFS_RUNNING, 0);
			check("halt", rd, 0);
		end
		apb(1, `OFS_COMPARE, 32'h0000_0301);
		apb(1, `OFS_MODE, 32'h0000_0846);
		apb(1, `OFS_START_TRIGGER, 1);
		send(2);
		apb(0, `OFS_COUNT, 0);
		check("split", rd, 32'h0000_0301);
		apb(0, `OFS_IRQ_STATUS, 0);
		check("split irq", rd, 1);
		apb(1, `OFS_IRQ_MASK, 0);
		repeat (2) @(posedge core_clk);
		check("mask", irq, 0);
		apb(1, `OFS_IRQ_MASK, 3);
		repeat (2) @(posedge core_clk);
		check("irq", irq, 1);
		apb(1, `OFS_IRQ_STATUS, 3);
		repeat (2) @(posedge core_clk);
		check("clr", irq, 0);
		finish_test;
	end
endmodule // external_event_counter_channel_bench
`default_nettype wire
